// ### logic/spi_eeprom_command_protect.sv
// SPI EEPROM command decoder, status register and write protection
`timescale 1ns/100ps
module spi_eeprom_command_protect
  import spi_prot_pkg::*;
#(
  parameter bit ID_VARIANT = 1'b1
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic select_n,
  input wire logic serial_clk,
  input wire logic data_in,
  input wire logic write_protect_n,
  output logic data_out,
  output logic data_out_en,
  output logic [7:0] status_out,
  output logic hardware_lock_mode,
  output logic array_write_go,
  output logic [14:0] array_write_addr,
  output logic id_lock_go,
  output logic [7:0] wdata,
  output logic wdata_valid,
  input wire logic wdata_ready,
  output logic array_read_start,
  output logic id_page_read_start,
  output logic lock_status_read_start
);
  // Synchronisers, first stage read only by second
  logic [1:0] sel_sync;
  logic [1:0] sck_sync;
  logic [1:0] din_sync;
  logic [1:0] wp_sync;
  logic sel_q;
  logic sck_q;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      sel_sync <= 2'h3;
      sck_sync <= 2'h0;
      din_sync <= 2'h0;
      wp_sync <= 2'h3;
      sel_q <= 1'b1;
      sck_q <= 1'b0;
    end
    else
    begin
      sel_sync <= {sel_sync[0], select_n};
      sck_sync <= {sck_sync[0], serial_clk};
      din_sync <= {din_sync[0], data_in};
      wp_sync <= {wp_sync[0], write_protect_n};
      sel_q <= sel_sync[1];
      sck_q <= sck_sync[1];
    end
  end

  logic sel_fall;
  logic sel_rise;
  logic sck_rise;
  logic sck_fall;
  logic selected;
  assign sel_fall = sel_q && !sel_sync[1];
  assign sel_rise = !sel_q && sel_sync[1];
  assign sck_rise = !sck_q && sck_sync[1] && !sel_sync[1];
  assign sck_fall = sck_q && !sck_sync[1] && !sel_sync[1];

  // Status bits
  logic [2:0] nv_bits; // lock, protect hi, protect lo
  logic write_latch_bit;
  logic cycle_busy_bit;
  logic [7:0] status_byte;
  assign status_byte = {nv_bits[2], 3'h0, nv_bits[1:0],
                        write_latch_bit, cycle_busy_bit};

  // Protected-range check for a given address
  function automatic logic in_protected(input logic [1:0] bp,
                                        input logic [14:0] a);
    unique case (bp)
      2'b00: in_protected = 1'b0;
      2'b01: in_protected = a >= RANGE_QUARTER;
      2'b10: in_protected = a >= RANGE_HALF;
      2'b11: in_protected = 1'b1;
    endcase
  endfunction

  // Frame state
  phase_e phase;
  logic armed; // seen a select fall since reset
  logic [7:0] shift_in;
  logic [2:0] bit_cnt;
  logic [7:0] opcode;
  logic [3:0] addr_cnt;
  logic [15:0] addr;
  logic [7:0] stat_new;
  logic data_bytes;
  logic byte_aligned;
  logic [7:0] shift_out;
  logic reading;
  logic [7:0] full_byte;
  assign full_byte = {shift_in[6:0], din_sync[1]};
  assign selected = armed && !sel_sync[1];

  // Arm after first select fall
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      armed <= 1'b0;
    end
    else if (sel_fall)
    begin
      armed <= 1'b1;
    end
  end

  // Opcode and address shifting, MSB first on rising clock
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || sel_fall)
    begin
      phase <= ST_OPCODE;
      bit_cnt <= 3'h0;
      shift_in <= 8'h00;
      opcode <= 8'h00;
      addr_cnt <= 4'h0;
      addr <= 16'h0000;
      data_bytes <= 1'b0;
      byte_aligned <= 1'b1;
      stat_new <= 8'h00;
      if (sys_rst)
      begin
        phase <= ST_IDLE;
      end
    end
    else if (selected && sck_rise && phase != ST_IDLE && phase != ST_DEAD)
    begin
      shift_in <= full_byte;
      bit_cnt <= bit_cnt + 3'h1;
      byte_aligned <= bit_cnt == 3'h7;
      if (phase == ST_ADDR)
      begin
        addr <= {addr[14:0], din_sync[1]};
        addr_cnt <= addr_cnt + 4'h1;
        if (addr_cnt == 4'hf)
        begin
          phase <= ST_DATA;
        end
      end
      if (bit_cnt == 3'h7)
      begin
        if (phase == ST_OPCODE)
        begin
          opcode <= full_byte;
          unique case (full_byte)
            OP_SET_LATCH, OP_CLR_LATCH, OP_STAT_READ: phase <= ST_DATA;
            OP_STAT_WRITE: phase <= ST_DATA;
            OP_ARRAY_READ, OP_ARRAY_WRITE: phase <= ST_ADDR;
            OP_ID_READ, OP_ID_WRITE:
              phase <= ID_VARIANT ? ST_ADDR : ST_DEAD;
            default: phase <= ST_DEAD;
          endcase
        end
        else if (phase == ST_DATA)
        begin
          data_bytes <= 1'b1;
          if (!data_bytes)
          begin
            stat_new <= full_byte;
          end
        end
      end
    end
  end

  // Read output shifter, changes on falling clock
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || !selected || phase == ST_DEAD)
    begin
      reading <= 1'b0;
      shift_out <= 8'h00;
      data_out <= 1'b0;
      data_out_en <= 1'b0;
    end
    else if (sck_fall && phase == ST_DATA && opcode == OP_STAT_READ
             && bit_cnt == 3'h0)
    begin
      reading <= 1'b1;
      shift_out <= {status_byte[6:0], 1'b0};
      data_out <= status_byte[7];
      data_out_en <= 1'b1;
    end
    else if (sck_fall && reading)
    begin
      shift_out <= {shift_out[6:0], 1'b0};
      data_out <= shift_out[7];
    end
  end

  // Execution conditions at select rising
  logic frame_ok;
  logic wr_addr_prot;
  assign frame_ok = armed && byte_aligned && phase == ST_DATA;
  assign wr_addr_prot = in_protected(nv_bits[1:0],
                                     addr[ADDR_BITS-1:0]);
  logic exec_set;
  logic exec_clr;
  logic exec_stat;
  logic exec_arr;
  logic exec_lock;
  assign exec_set = sel_rise && frame_ok && !data_bytes
                    && opcode == OP_SET_LATCH;
  assign exec_clr = sel_rise && frame_ok && !data_bytes
                    && opcode == OP_CLR_LATCH;
  assign exec_stat = sel_rise && frame_ok && data_bytes && !cycle_busy_bit
                     && opcode == OP_STAT_WRITE && write_latch_bit
                     && !hardware_lock_mode;
  assign exec_arr = sel_rise && frame_ok && data_bytes && !cycle_busy_bit
                    && write_latch_bit
                    && ((opcode == OP_ARRAY_WRITE && !wr_addr_prot)
                    || (opcode == OP_ID_WRITE && !addr[ID_SEL_POS]));
  assign exec_lock = sel_rise && frame_ok && data_bytes && !cycle_busy_bit
                     && write_latch_bit && opcode == OP_ID_WRITE
                     && addr[ID_SEL_POS];

  // Hardware lock mode from lock bit and protect pin
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      hardware_lock_mode <= 1'b0;
    end
    else
    begin
      hardware_lock_mode <= nv_bits[2] && !wp_sync[1];
    end
  end

  // Self-timed write cycle and busy bit
  logic [15:0] cyc_cnt;
  logic stat_pending;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cycle_busy_bit <= 1'b0;
      cyc_cnt <= 16'h0000;
      stat_pending <= 1'b0;
    end
    else if (exec_stat || exec_arr || exec_lock)
    begin
      cycle_busy_bit <= 1'b1;
      cyc_cnt <= 16'(WRITE_CYCLES - 1);
      stat_pending <= exec_stat;
    end
    else if (cycle_busy_bit)
    begin
      if (cyc_cnt == 16'h0000)
      begin
        cycle_busy_bit <= 1'b0;
        stat_pending <= 1'b0;
      end
      else
      begin
        cyc_cnt <= cyc_cnt - 16'h0001;
      end
    end
  end

  // Non-volatile protect bits, updated at end of status write cycle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      nv_bits <= NV_RESET; // models stored value at first power-up
    end
    else if (stat_pending && cycle_busy_bit && cyc_cnt == 16'h0000)
    begin
      nv_bits <= {stat_new[STAT_LOCK_POS], stat_new[STAT_BP_HI_POS],
                  stat_new[STAT_BP_LO_POS]};
    end
  end

  // Write latch
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      write_latch_bit <= 1'b0;
    end
    else if (exec_set)
    begin
      write_latch_bit <= 1'b1;
    end
    else if (exec_clr || (cycle_busy_bit && cyc_cnt == 16'h0000))
    begin
      write_latch_bit <= 1'b0;
    end
  end

  // Data bytes of array and id writes go to the array path through the FIFO
  logic byte_push;
  logic f_valid;
  logic [7:0] f_data;
  assign byte_push = selected && sck_rise && phase == ST_DATA
                     && bit_cnt == 3'h7 && (opcode == OP_ARRAY_WRITE
                     || opcode == OP_ID_WRITE);
  spi_prot_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) data_fifo (
    .clk(sys_clk),
    .rst(sys_rst),
    .in_valid(byte_push),
    .in_ready(),
    .in_data(full_byte),
    .out_valid(f_valid),
    .out_ready(wdata_ready && !wdata_valid),
    .out_data(f_data)
  );

  // Registered outputs
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      status_out <= 8'h00;
      array_write_go <= 1'b0;
      array_write_addr <= 15'h0000;
      id_lock_go <= 1'b0;
      wdata <= 8'h00;
      wdata_valid <= 1'b0;
      array_read_start <= 1'b0;
      id_page_read_start <= 1'b0;
      lock_status_read_start <= 1'b0;
    end
    else
    begin
      status_out <= status_byte;
      array_write_go <= exec_arr;
      array_write_addr <= addr[ADDR_BITS-1:0];
      id_lock_go <= exec_lock;
      wdata_valid <= f_valid && wdata_ready && !wdata_valid;
      if (f_valid && wdata_ready && !wdata_valid)
      begin
        wdata <= f_data;
      end
      array_read_start <= selected && sck_rise && phase == ST_ADDR
                          && addr_cnt == 4'hf && opcode == OP_ARRAY_READ
                          && !cycle_busy_bit;
      id_page_read_start <= selected && sck_rise && phase == ST_ADDR
                            && addr_cnt == 4'hf && opcode == OP_ID_READ
                            && !addr[ID_SEL_POS - 1];
      lock_status_read_start <= selected && sck_rise && phase == ST_ADDR
                                && addr_cnt == 4'hf && opcode == OP_ID_READ
                                && addr[ID_SEL_POS - 1];
    end
  end
endmodule

// ### logic/spi_prot_pkg.sv
// Constants and types for the SPI EEPROM command and protection block
// Contract
// - Writes and status writes run only if clock pulse count is a multiple of eight.
// - Every modifying command needs the write latch set first by its own command.
// - Select must rise after the last command bit's edge, before the next.
// - Last bit is opcode or data byte bit eight; reads are exempt.
// - Protect code 00 none, 01 6000h up, 10 4000h up, 11 everything.
// - Commands start with an eight-bit opcode from the fixed set.
// - Unknown opcode deselects internally until the next select assertion.
// - Id variant 1000 0011 reads id page or lock status by bit A10.
// - Id variant 1000 0010 writes id page or locks it by bit A10.
// - Only address bits 14 down to 0 are decoded.
// - Write latch sets only after set-latch opcode and select rising.
// - Write latch clears on reset, clear command, status write, array write.
// - Status read is accepted at any time, even during a write cycle.
// - Status byte repeats while select stays low after a status read.
// - Busy bit reads one during a write cycle, zero otherwise.
// - Write latch clear rejects array writes and status writes.
// - Protect bits are kept, changed only by status write outside lock mode.
// - Array writes into the protected range are rejected.
// - Lock bit set with protect pin low enters hardware lock mode.
// - Status byte: lock, three zeros, protect hi, protect lo, latch, busy.
// - MSB first; sample on rising clock edge, drive on falling edge.
// - Reset clears latch and busy, keeps protect bits, deselects; here reset loads NV_RESET into the protect and lock bits.
// - After reset no selection until a falling select edge is seen.
package spi_prot_pkg;
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STAT_READ = 8'h05;
  localparam logic [7:0] OP_STAT_WRITE = 8'h01;
  localparam logic [7:0] OP_ARRAY_READ = 8'h03;
  localparam logic [7:0] OP_ARRAY_WRITE = 8'h02;
  localparam logic [7:0] OP_ID_READ = 8'h83;
  localparam logic [7:0] OP_ID_WRITE = 8'h82;
  localparam int ID_SEL_POS = 10;
  localparam int ADDR_BITS = 15;
  localparam logic [14:0] RANGE_QUARTER = 15'h6000;
  localparam logic [14:0] RANGE_HALF = 15'h4000;
  localparam int STAT_LOCK_POS = 7;
  localparam int STAT_BP_HI_POS = 3;
  localparam int STAT_BP_LO_POS = 2;
  localparam int STAT_LATCH_POS = 1;
  localparam int STAT_BUSY_POS = 0;
  localparam logic [2:0] NV_RESET = 3'h0;
  localparam int WRITE_TIME_US = 5;
  localparam int CLK_MHZ = 25;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam int FIFO_DEPTH = 4;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPCODE = 3'b001,
    ST_ADDR = 3'b011,
    ST_DATA = 3'b010,
    ST_DEAD = 3'b110
  } phase_e;
endpackage

// ### logic/spi_prot_fifo.sv
// Small valid/ready FIFO for received data bytes
`timescale 1ns/100ps
module spi_prot_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;

  // Handshake and flags
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];

  // Storage
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// ### tb/spi_master_model.sv
// Behavioural SPI bus master for the serial side of the block
`timescale 1ns/100ps
module spi_master_model (
  input wire logic clk,
  output logic select_n,
  output logic serial_clk,
  output logic data_in,
  input wire logic data_out,
  input wire logic data_out_en
);
  // Bus idle: deselected, clock low until the first frame; between frames it rests at cpol
  initial
  begin
    select_n = 1'b1;
    serial_clk = 1'b0;
    data_in = 1'b0;
  end

  // One frame of n bits, MSB first; cpol picks the clock's idle level
  // Pins move only on rising clk edges, by non-blocking assignment
  task automatic xfer(input logic [31:0] tx, input int n, input logic cpol,
                      output logic [31:0] rx);
    int i;
    rx = '0;
    @(posedge clk);
    serial_clk <= cpol; // Idle level settles while still deselected
    repeat (4) @(posedge clk);
    select_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (i = n - 1; i >= 0; i--)
    begin
      serial_clk <= 1'b0; // Falling edge in idle-high mode
      data_in <= tx[i];
      repeat (4) @(posedge clk);
      serial_clk <= 1'b1;
      // Released line reads back inverted, never a stale value
      rx = {rx[30:0], (data_out_en === 1'b1) ? data_out : ~rx[0]};
      repeat (4) @(posedge clk);
    end
    serial_clk <= cpol;
    select_n <= 1'b1;
    data_in <= ~data_in;
    repeat (8) @(posedge clk);
  endtask
endmodule

// ### tb/spi_eeprom_command_protect_sva.sv
// Port checks for the SPI EEPROM command and protection block
`timescale 1ns/100ps
module spi_eeprom_command_protect_sva
  import spi_prot_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic select_n,
  input wire logic write_protect_n,
  input wire logic data_out_en,
  input wire logic [7:0] status_out,
  input wire logic hardware_lock_mode,
  input wire logic array_write_go,
  input wire logic [14:0] array_write_addr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Address lies in the range guarded by the protect code
  function automatic logic guarded(input logic [1:0] bp,
                                   input logic [14:0] a);
    case (bp)
      2'b01: return a >= RANGE_QUARTER;
      2'b10: return a >= RANGE_HALF;
      2'b11: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  a_latch_on_desel: assert property ($rose(status_out[1]) |-> select_n)
    else $error("write latch set while selected");
  a_write_has_latch: assert property (array_write_go |-> status_out[1])
    else $error("write started with latch clear");
  a_busy_follows: assert property (
    array_write_go |-> ##[0:2] status_out[0])
    else $error("busy bit missing after write start");
  a_busy_end_latch: assert property (
    $fell(status_out[0]) |-> ##[0:1] !status_out[1])
    else $error("latch still set after write cycle");
  a_hw_lock_level: assert property (
    ($stable(write_protect_n) && $stable(status_out[7]))[*4]
    |-> hardware_lock_mode == (status_out[7] && !write_protect_n))
    else $error("lock mode disagrees with lock bit and pin");
  a_locked_keeps: assert property (
    hardware_lock_mode && $past(hardware_lock_mode)
    |-> $stable(status_out[7:2]))
    else $error("protect bits changed in lock mode");
  a_upper_zero: assert property (status_out[6:4] == 3'h0)
    else $error("status bits 6..4 not zero");
  a_hiz_desel: assert property (select_n[*5] |-> !data_out_en)
    else $error("output driven while deselected");
  a_range_kept: assert property (
    array_write_go |-> !guarded(status_out[3:2], array_write_addr))
    else $error("write started inside protected range");
endmodule

bind spi_eeprom_command_protect spi_eeprom_command_protect_sva u_sva (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .select_n(select_n),
  .write_protect_n(write_protect_n),
  .data_out_en(data_out_en),
  .status_out(status_out),
  .hardware_lock_mode(hardware_lock_mode),
  .array_write_go(array_write_go),
  .array_write_addr(array_write_addr)
);

// ### tb/testbench.sv
// Self-checking bench for the SPI EEPROM command and protection block
`timescale 1ns/100ps
module testbench;
  import spi_prot_pkg::*;
  logic sys_clk, sys_rst, write_protect_n, wdata_ready;
  logic select_n, serial_clk, data_in, data_out, data_out_en;
  logic hardware_lock_mode, array_write_go, id_lock_go, wdata_valid;
  logic array_read_start, id_page_read_start, lock_status_read_start;
  logic [7:0] status_out, wdata;
  logic [14:0] array_write_addr;
  logic [31:0] rx;
  logic idle_hi = 1'b0;
  logic [7:0] last_wd = 8'h00;
  int n_go = 0, n_rd = 0, n_id = 0, n_lk = 0, n_il = 0, g;
  int n_mismatch = 0, num_checks = 0;
  logic [7:0] bp_tab [3] = '{8'h04, 8'h08, 8'h0c};
  logic [15:0] lim_tab [3] = '{16'h6000, 16'h4000, 16'h0000};

  spi_eeprom_command_protect u_dut (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .select_n(select_n), .serial_clk(serial_clk),
    .data_in(data_in), .write_protect_n(write_protect_n),
    .data_out(data_out), .data_out_en(data_out_en),
    .status_out(status_out), .hardware_lock_mode(hardware_lock_mode),
    .array_write_go(array_write_go), .array_write_addr(array_write_addr),
    .id_lock_go(id_lock_go), .wdata(wdata), .wdata_valid(wdata_valid),
    .wdata_ready(wdata_ready), .array_read_start(array_read_start),
    .id_page_read_start(id_page_read_start),
    .lock_status_read_start(lock_status_read_start));
  spi_master_model u_master (.clk(sys_clk), .select_n(select_n),
    .serial_clk(serial_clk), .data_in(data_in), .data_out(data_out),
    .data_out_en(data_out_en));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Pulse counters and last received byte
  always @(posedge sys_clk)
  begin
    n_go <= n_go + int'(array_write_go === 1'b1);
    n_rd <= n_rd + int'(array_read_start === 1'b1);
    n_id <= n_id + int'(id_page_read_start === 1'b1);
    n_lk <= n_lk + int'(lock_status_read_start === 1'b1);
    n_il <= n_il + int'(id_lock_go === 1'b1);
    if (wdata_valid === 1'b1)
      last_wd <= wdata;
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmd(input logic [31:0] tx, input int n);
    u_master.xfer(tx, n, idle_hi, rx);
  endtask

  // Poll the busy bit, bounded
  task automatic wait_idle();
    int i;
    for (i = 0; i < 400 && status_out[0] !== 1'b0; i++)
      @(posedge sys_clk);
    if (i == 400)
    begin
      chk("busy timeout", 32'h1, 32'h0);
      test_done();
    end
  endtask

  task automatic wr_status(input logic [7:0] v);
    cmd(32'(OP_SET_LATCH), 8);
    cmd({16'h0, OP_STAT_WRITE, v}, 16);
    chk("busy", 32'(status_out[0]), 32'h1);
    wait_idle();
  endtask

  initial
  begin
    sys_rst = 1'b1;
    write_protect_n = 1'b1;
    wdata_ready = 1'b1;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("status reset", 32'(status_out), 32'h00);
    cmd(32'(OP_SET_LATCH), 8);
    chk("latch set", 32'(status_out), 32'h02);
    cmd(32'(OP_CLR_LATCH), 8);
    chk("latch clr", 32'(status_out), 32'h00);
    cmd({OP_ARRAY_WRITE, 16'h0010, 8'ha5}, 32);
    cmd({16'h0, OP_STAT_WRITE, 8'h8c}, 16);
    chk("no latch wr", 32'(n_go), 32'h0);
    chk("no latch sw", 32'(status_out), 32'h00);
    wr_status(8'h8c);
    chk("status wr", 32'(status_out), 32'h8c);
    cmd({8'h0, OP_STAT_READ, 16'h0}, 24);
    chk("status rd", 32'(rx[15:0]), 32'h8c8c);
    chk("released", 32'(data_out_en), 32'h0);
    idle_hi = 1'b1;
    cmd({16'h0, OP_STAT_READ, 8'h0}, 16);
    chk("idle high rd", 32'(rx[7:0]), 32'h8c);
    idle_hi = 1'b0;
    write_protect_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk("hw lock", 32'(hardware_lock_mode), 32'h1);
    cmd(32'(OP_SET_LATCH), 8);
    cmd({16'h0, OP_STAT_WRITE, 8'h00}, 16);
    repeat (8) @(posedge sys_clk);
    chk("locked", 32'(status_out[7:2]), 32'h23);
    write_protect_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    for (int k = 0; k < 3; k++)
    begin
      wr_status(bp_tab[k]);
      chk("bp set", 32'(status_out), 32'(bp_tab[k]));
      g = n_go;
      cmd(32'(OP_SET_LATCH), 8);
      cmd({OP_ARRAY_WRITE, lim_tab[k] | 16'h8000, 8'h5a}, 32);
      wait_idle();
      chk("guarded", 32'(n_go), 32'(g));
      if (lim_tab[k] != 16'h0000)
      begin
        cmd(32'(OP_SET_LATCH), 8);
        cmd({OP_ARRAY_WRITE, (lim_tab[k] - 16'h1) | 16'h8000, 8'h5a}, 32);
        chk("open", 32'(n_go), 32'(g + 1));
        chk("addr", 32'(array_write_addr), 32'(lim_tab[k] - 16'h1));
        chk("byte", 32'(last_wd), 32'h5a);
        cmd({16'h0, OP_STAT_READ, 8'h0}, 16);
        chk("busy rd", 32'(rx[7:0]), 32'(bp_tab[k] | 8'h03));
        wait_idle();
        chk("latch drop", 32'(status_out), 32'(bp_tab[k]));
      end
    end
    wr_status(8'h00);
    g = n_go;
    cmd(32'(OP_SET_LATCH), 8);
    cmd({OP_ARRAY_WRITE, 16'h0100, 7'h11}, 31);
    chk("odd count", 32'(n_go), 32'(g));
    cmd(32'(OP_CLR_LATCH), 8);
    cmd({16'h0, 8'hff, OP_SET_LATCH}, 16);
    chk("bad opcode", 32'(status_out), 32'h00);
    cmd({8'h0, 8'hff, OP_STAT_READ, 8'h00}, 24);
    chk("dead quiet", 32'(rx[7:0]), 32'haa);
    cmd({OP_ID_READ, 16'h0400, 8'h0}, 32);
    chk("lock rd", 32'(n_lk), 32'h1);
    cmd({OP_ID_READ, 16'hfbff, 8'h0}, 32);
    chk("id rd", 32'(n_id), 32'h1);
    cmd({OP_ARRAY_READ, 16'h0000, 8'h0}, 32);
    chk("array rd", 32'(n_rd), 32'h1);
    g = n_go;
    cmd(32'(OP_SET_LATCH), 8);
    cmd({OP_ID_WRITE, 16'h0400, 8'h00}, 32);
    chk("id lock", 32'(n_il), 32'h1);
    chk("no page wr", 32'(n_go), 32'(g));
    wait_idle();
    cmd(32'(OP_SET_LATCH), 8);
    cmd({OP_ID_WRITE, 16'hfbff, 8'h3c}, 32);
    chk("page wr", 32'(n_go), 32'(g + 1));
    chk("page byte", 32'(last_wd), 32'h3c);
    chk("lock once", 32'(n_il), 32'h1);
    wait_idle();
    test_done();
  end
endmodule
